// ==== bench/sram_host_chk.sv ====
// Checker on the pins and answers of the static RAM host controller
`timescale 1ns/100ps
`default_nettype none
module sram_host_chk #(
    parameter int AW = 15,
    parameter int DW = 8
)(
    input wire logic          CLK,
    input wire logic          NRST,
    input wire logic          REQ_VALID,
    input wire logic          REQ_WRITE,
    input wire logic          REQ_READY,
    input wire logic          RSP_VALID,
    input wire logic          WRITE_DONE,
    input wire logic          RETAIN_SAFE,
    input wire logic [AW-1:0] WORD_ADDRESS,
    input wire logic [DW-1:0] DATA_LINES_OUT,
    input wire logic          DATA_LINES_OE,
    input wire logic          SELECT_N,
    input wire logic          WSTROBE_N,
    input wire logic          OGATE_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Strobe and select overlap for three whole cycles, then both rise together
    property p_wr_pulse; $fell(WSTROBE_N) |-> (!SELECT_N && !WSTROBE_N)[*3] ##1 (SELECT_N && WSTROBE_N); endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too short or too long");
    property p_addr_set; (!SELECT_N && !WSTROBE_N) |-> $stable(WORD_ADDRESS) && DATA_LINES_OE; endproperty
    a_addr_set: assert property (p_addr_set) else $error("address moved during write");
    property p_end_hold;
        $rose(WSTROBE_N) |-> $stable(WORD_ADDRESS) && $stable(DATA_LINES_OUT) && DATA_LINES_OE;
    endproperty
    a_end_hold: assert property (p_end_hold) else $error("address or data dropped at end of write");
    property p_no_clash; !OGATE_N |-> !DATA_LINES_OE && WSTROBE_N; endproperty
    a_no_clash: assert property (p_no_clash) else $error("host drives or strobes during read");
    property p_rd_gate; $fell(OGATE_N) |-> (!SELECT_N && !OGATE_N)[*3] ##1 (SELECT_N && OGATE_N); endproperty
    a_rd_gate: assert property (p_rd_gate) else $error("read window not three cycles");
    // Read answer is registered at the edge that closes the three-cycle window
    property p_rd_lat; REQ_READY && REQ_VALID && !REQ_WRITE |-> ##4 RSP_VALID; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_wr_lat; REQ_READY && REQ_VALID && REQ_WRITE |-> ##6 WRITE_DONE; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_retain; RETAIN_SAFE |-> SELECT_N && WSTROBE_N && OGATE_N && !DATA_LINES_OE && !REQ_READY; endproperty
    a_retain: assert property (p_retain) else $error("memory pins active while in retention");
    // Select stays high for one read cycle after the supply comes back
    property p_recover; $fell(RETAIN_SAFE) |-> (SELECT_N && !REQ_READY)[*2] ##1 SELECT_N; endproperty
    a_recover: assert property (p_recover) else $error("access too soon after retention");
endmodule
bind sram_host sram_host_chk #(.AW(AW), .DW(DW)) u_chk (
    .CLK(CLK), .NRST(NRST), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_READY(REQ_READY),
    .RSP_VALID(RSP_VALID), .WRITE_DONE(WRITE_DONE), .RETAIN_SAFE(RETAIN_SAFE), .WORD_ADDRESS(WORD_ADDRESS),
    .DATA_LINES_OUT(DATA_LINES_OUT), .DATA_LINES_OE(DATA_LINES_OE), .SELECT_N(SELECT_N),
    .WSTROBE_N(WSTROBE_N), .OGATE_N(OGATE_N));
`default_nettype wire

// ==== bench/sram_host_tb_top.sv ====
// Self-checking bench for the static RAM host controller
`timescale 1ns/100ps
`default_nettype none
module sram_host_tb_top import sram_host_pkg::*;;
    typedef struct packed { logic wr; logic [ADDR_W-1:0] addr; logic [DATA_W-1:0] data; } row_t;
    logic              clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0, retain_req = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0, word_address;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, data_out, data_in;
    logic              req_ready, rsp_valid, write_done, retain_safe, busy, data_oe, sel_n, wstb_n, gate_n;
    int                miscompares = 0, compares = 0, cycles = 0, n;
    // Writes then reads, corner addresses and all-ones/zeros data
    row_t rows [10] = '{{1'b1,15'h0000,8'ha5}, {1'b1,15'h7fff,8'h3c}, {1'b1,15'h4000,8'hc3},
        {1'b1,15'h5555,8'hff}, {1'b0,15'h0000,8'ha5}, {1'b0,15'h7fff,8'h3c}, {1'b0,15'h4000,8'hc3},
        {1'b0,15'h5555,8'hff}, {1'b1,15'h0000,8'h00}, {1'b0,15'h0000,8'h00}};
    sram_host DUT (
        .CLK(clk), .NRST(nrst), .REQ_VALID(req_valid), .REQ_WRITE(req_write), .REQ_ADDR(req_addr),
        .REQ_WDATA(req_wdata), .REQ_READY(req_ready), .RSP_RDATA(rsp_rdata), .RSP_VALID(rsp_valid),
        .WRITE_DONE(write_done), .RETAIN_REQ(retain_req), .RETAIN_SAFE(retain_safe), .BUSY(busy),
        .WORD_ADDRESS(word_address), .DATA_LINES_IN(data_in), .DATA_LINES_OUT(data_out),
        .DATA_LINES_OE(data_oe), .SELECT_N(sel_n), .WSTROBE_N(wstb_n), .OGATE_N(gate_n));
    sram_model #(.SEL_NS(118), .GATE_NS(58)) u_mem (
        .word_address(word_address), .host_data(data_out), .host_oe(data_oe), .select_n(sel_n),
        .wstrobe_n(wstb_n), .ogate_n(gate_n), .data_lines(data_in));
    always #20 clk = ~clk;
    // Cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Offer one request, wait for take, then time its answer
    task automatic access(input row_t r, output int waited);
        int k;
        int want;
        @(posedge clk);
        req_valid <= 1'b1;
        {req_write, req_addr, req_wdata} <= r;
        waited = 0;
        do begin @(negedge clk); waited++; end while (req_ready !== 1'b1 && waited < 40);
        @(posedge clk);
        req_valid <= 1'b0;
        for (k = 0; k < 9; k++) begin
            @(negedge clk);
            if ((r.wr ? write_done : rsp_valid) === 1'b1) break;
        end
        // Cycles after the take: set-up, pulse and recovery for a write,
        // the access window alone for a read
        want = r.wr ? 1 + WRITE_PULSE_CYC + WRITE_RECOV_CYC : READ_WAIT_CYC;
        chk("answer cycle", 16'(want), 16'(k));
        if (!r.wr) chk("read data", 16'(r.data), 16'(rsp_rdata));
    endtask
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        chk("reset pins", 16'h0001, 16'({sel_n & wstb_n & gate_n, data_oe, busy, req_ready} == 4'h8));
        nrst <= 1'b1;
        foreach (rows[i]) access(rows[i], n);
        // Retention: a request waits, contents survive, recovery wait
        @(posedge clk);
        retain_req <= 1'b1;
        // Float wait ends, one idle cycle, then the retention state
        repeat (3) @(negedge clk);
        chk("retain safe", 16'h0001, 16'(retain_safe & sel_n));
        fork
            access({1'b0, 15'h7fff, 8'h3c}, n);
            begin repeat (4) @(posedge clk); retain_req <= 1'b0; end
        join
        chk("recovery wait", 16'h0001, 16'(n >= 7));
        // Reset in mid-write releases the pins at once; the request drops at its take
        @(posedge clk);
        req_valid <= 1'b1;
        {req_write, req_addr, req_wdata} <= {1'b1, 15'h1234, 8'h77};
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b0;
        // Strobe is low from the edge after the set-up cycle
        repeat (2) @(posedge clk);
        nrst <= 1'b0;
        @(negedge clk);
        chk("reset release", 16'h0001, 16'(sel_n & wstb_n & gate_n & ~data_oe & ~busy));
        @(posedge clk);
        nrst <= 1'b1;
        access({1'b0, 15'h4000, 8'hc3}, n);
        end_sim();
    end
endmodule
`default_nettype wire

// ==== bench/sram_model.sv ====
// Behavioural model of the 32K x 8 static RAM on the host's pins
`timescale 1ns/100ps
`default_nettype none
module sram_model #(
    parameter int AW      = 15,
    parameter int DW      = 8,
    parameter int SEL_NS  = 10,        // Access time from select
    parameter int GATE_NS = 10         // Access time from output gate
)(
    input wire logic [AW-1:0] word_address,
    input wire logic [DW-1:0] host_data,
    input wire logic          host_oe,
    input wire logic          select_n,
    input wire logic          wstrobe_n,
    input wire logic          ogate_n,
    output logic [DW-1:0]     data_lines
);
    logic [DW-1:0] mem [0:(1<<AW)-1];           // Static array, no refresh
    logic          sel_ok  = 1'b0;              // Select low long enough
    logic          gate_ok = 1'b0;              // Gate low long enough
    wire           drive = !select_n && wstrobe_n && !ogate_n;
    // Data turns valid only after the access times
    always @(select_n) sel_ok <= #(SEL_NS) !select_n;
    always @(ogate_n) gate_ok <= #(GATE_NS) !ogate_n;
    // Store while select and strobe overlap, gate ignored; an undriven bus stores garbage
    always @* if (!select_n && !wstrobe_n) mem[word_address] = host_oe ? host_data : ~host_data;
    // Clash is unknown; early data and a floating wire show garbage
    always @* begin
        if (drive && host_oe) data_lines = 'x;
        else if (drive && sel_ok && gate_ok) data_lines = mem[word_address];
        else if (drive) data_lines = ~mem[word_address];
        else if (host_oe) data_lines = host_data;
        else data_lines = ~host_data;
    end
endmodule
`default_nettype wire

// ==== include/sram_host_pkg.sv ====
// Package: constants for the static RAM host controller
package sram_host_pkg;
    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int ADDR_W      = 15;         // Word address width
    localparam int DATA_W      = 8;          // Data lines width
    localparam int WORD_COUNT  = 32768;      // Words in the array
    // ------------------------------------------------------------
    // Timing, slowest speed grade, in ns
    // ------------------------------------------------------------
    localparam int CLK_NS          = 40;     // Clock period
    localparam int WRITE_PULSE_NS  = 90;     // Least select and strobe overlap
    localparam int WRITE_RECOV_NS  = 10;     // Least recovery after write
    localparam int READ_ACCESS_NS  = 120;    // Longest access from select
    localparam int GATE_ACCESS_NS  = 60;     // Longest access from output gate
    localparam int READ_CYCLE_NS   = 120;    // Read cycle time
    localparam int GATE_FLOAT_NS   = 60;     // Longest float after gate release
    // Cycle counts: least times round up, none below one
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_RECOV_CYC = (WRITE_RECOV_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_WAIT_CYC   = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_CYCLE_CYC  = (READ_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int FLOAT_CYC       = (GATE_FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W           = 4;      // Width of the phase counter
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0; // Counter reset value
endpackage

// ==== rtl/sram_host.sv ====
// Host controller driving an asynchronous 32K x 8 static RAM
//
// What this block does
// - Address stable before select and strobe fall
// - Hold address, data until strobe rises
// - Select and strobe low for write pulse
// - Never drive data lines while device drives
// - Deselect before retention, wait after recovery
`timescale 1ns/100ps
`default_nettype none
module sram_host
    import sram_host_pkg::*;
#(
    parameter int AW = ADDR_W,                // Word address width
    parameter int DW = DATA_W                 // Data width
)(
    input  wire logic          CLK,
    input  wire logic          NRST,
    // User side
    input  wire logic          REQ_VALID,     // Request offered
    input  wire logic          REQ_WRITE,     // High for a write
    input  wire logic [AW-1:0] REQ_ADDR,      // Word address
    input  wire logic [DW-1:0] REQ_WDATA,     // Write data
    output logic               REQ_READY,     // Request taken this cycle
    output logic [DW-1:0]      RSP_RDATA,     // Read data
    output logic               RSP_VALID,     // One-cycle read answer
    output logic               WRITE_DONE,    // One-cycle write answer
    input  wire logic          RETAIN_REQ,    // Ask to enter low supply retention
    output logic               RETAIN_SAFE,   // Memory deselected, supply may drop
    output logic               BUSY,          // Access, retention or recovery in progress
    // Memory pins
    output logic [AW-1:0]      WORD_ADDRESS,  // Address pins
    input  wire logic [DW-1:0] DATA_LINES_IN, // Data line levels
    output logic [DW-1:0]      DATA_LINES_OUT,// Data driven by us
    output logic               DATA_LINES_OE, // High while we drive data
    output logic               SELECT_N,      // Select, active low
    output logic               WSTROBE_N,     // Write strobe, active low
    output logic               OGATE_N        // Output gate, active low
);
    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        S_IDLE   = 7'b0000001,                // Deselected, waiting
        S_WSET   = 7'b0000010,                // Address and data set up
        S_WPULSE = 7'b0000100,                // Select and strobe low
        S_WRECOV = 7'b0001000,                // Strobe high, recovery
        S_RACC   = 7'b0010000,                // Select and gate low
        S_RFLOAT = 7'b0100000,                // Gate high, device floats
        S_RETAIN = 7'b1000000                 // Supply may be lowered
    } state_t;

    state_t           state;                  // Current state
    state_t           next_state;             // Next state
    logic             expired;                // Phase timer done
    logic             load;                   // Start phase timer
    logic [CNT_W-1:0] length;                 // Phase length
    logic [AW-1:0]    addr;                   // Latched address
    logic [DW-1:0]    wdata;                  // Latched write data
    logic             retain_exit;            // Coming back from retention

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire logic in_idle   = (state == S_IDLE);
    // Retention wins over a new access; nothing is taken during recovery wait.
    // Ready is combinational, so the user sees the take in the same cycle and
    // can drop its request at the very edge that consumed it.
    wire logic take      = in_idle && expired && REQ_VALID && !RETAIN_REQ;
    wire logic go_retain = in_idle && expired && RETAIN_REQ;

    // Next state and timer loads
    always_comb begin
        next_state = state;
        load       = 1'b0;
        length     = CNT_ZERO;
        unique case (state)
            S_IDLE: begin
                if (go_retain) begin
                    next_state = S_RETAIN;
                end else if (take && REQ_WRITE) begin
                    next_state = S_WSET;
                end else if (take) begin
                    // Read: access time from select covers gate access too
                    next_state = S_RACC;
                    load       = 1'b1;
                    length     = CNT_W'(READ_WAIT_CYC);
                end
            end
            S_WSET: begin
                // Address settled a cycle before the strobe falls
                next_state = S_WPULSE;
                load       = 1'b1;
                length     = CNT_W'(WRITE_PULSE_CYC);
            end
            S_WPULSE: begin
                if (expired) begin
                    next_state = S_WRECOV;
                    load       = 1'b1;
                    length     = CNT_W'(WRITE_RECOV_CYC);
                end
            end
            S_WRECOV: begin
                if (expired) begin
                    next_state = S_IDLE;
                end
            end
            S_RACC: begin
                if (expired) begin
                    next_state = S_RFLOAT;
                    load       = 1'b1;
                    length     = CNT_W'(FLOAT_CYC);
                end
            end
            S_RFLOAT: begin
                // Keep off the data lines until the device has floated
                if (expired) begin
                    next_state = S_IDLE;
                end
            end
            S_RETAIN: begin
                if (!RETAIN_REQ) begin
                    // Wait one read cycle after supply recovers
                    next_state = S_IDLE;
                    load       = 1'b1;
                    length     = CNT_W'(READ_CYCLE_CYC);
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Phase timer
    // ------------------------------------------------------------
    sram_phase_timer u_timer (
        .clk     (CLK),
        .nrst    (NRST),
        .load    (load),
        .length  (length),
        .expired (expired)
    );

    // State register
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Latch address and data when a request is taken
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            addr  <= '0;
            wdata <= '0;
        end else if (take) begin
            addr  <= REQ_ADDR;
            wdata <= REQ_WDATA;
        end
    end

    // ------------------------------------------------------------
    // Pin drive, registered
    // ------------------------------------------------------------
    wire logic n_write = (next_state == S_WSET) || (next_state == S_WPULSE) || (next_state == S_WRECOV);
    wire logic n_sel   = (next_state == S_WPULSE) || (next_state == S_RACC);
    wire logic n_strb  = (next_state == S_WPULSE);
    wire logic n_gate  = (next_state == S_RACC);
    // Read data is sampled at the edge that closes the access window, while
    // select and gate are still low, so the device is still driving
    wire logic capture = (state == S_RACC) && expired;

    // Control pins come from flip-flops so no glitch reaches the memory
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SELECT_N      <= 1'b1;
            WSTROBE_N     <= 1'b1;
            OGATE_N       <= 1'b1;
            DATA_LINES_OE <= 1'b0;
        end else begin
            SELECT_N      <= !n_sel;
            WSTROBE_N     <= !n_strb;
            OGATE_N       <= !n_gate;
            DATA_LINES_OE <= n_write;
        end
    end

    // Read data and one-cycle answers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RSP_RDATA  <= '0;
            RSP_VALID  <= 1'b0;
            WRITE_DONE <= 1'b0;
            retain_exit <= 1'b0;
        end else begin
            RSP_VALID   <= capture;
            WRITE_DONE  <= (state == S_WRECOV) && expired;
            retain_exit <= (state == S_RETAIN);
            if (capture) begin
                RSP_RDATA <= DATA_LINES_IN;
            end
        end
    end

    // Address and write data only move on a take, which gives the hold after
    // the strobe rises and keeps the bus quiet between accesses
    assign WORD_ADDRESS   = addr;
    assign DATA_LINES_OUT = wdata;
    assign REQ_READY      = take;
    assign RETAIN_SAFE    = (state == S_RETAIN) && SELECT_N;
    assign BUSY           = !in_idle || !expired || retain_exit;
endmodule
`default_nettype wire

// ==== rtl/sram_phase_timer.sv ====
// Down counter that marks the end of each timed bus phase
`timescale 1ns/100ps
`default_nettype none
module sram_phase_timer
    import sram_host_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             load,       // Start a new phase
    input  wire logic [CNT_W-1:0] length,     // Phase length in cycles
    output logic                  expired     // Phase has run out
);
    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic [CNT_W-1:0] remaining;              // Cycles left in phase
    wire  logic       running = (remaining != CNT_ZERO);

    // Load one less than the length, then count to zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            remaining <= CNT_ZERO;
        end else if (load) begin
            remaining <= length - 4'h1;
        end else if (running) begin
            remaining <= remaining - 4'h1;
        end
    end

    // Done once the count sits at zero; load stays out of this term because
    // the idle decode feeds load, and a path back through it would loop
    assign expired = !running;
endmodule
`default_nettype wire
